// *** verilog/rot_rename_pkg.sv ***
// Constants, state types and index helpers shared by the rotating renamer.
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Physical index is architectural number plus the file's rotating base.
// - Bases decrement only on a pipelined loop branch; a legal frame write resets the general base to zero.
// - A decrement shows old X as X+1; the top register wraps to the bottom.
// - Predicates rotate over p16-p63, floats over f32-f127; others never rename.
// - General rotating size is zero or multiple of 8, at most 96.
// - The general rotating region starts at r32 and spans the programmed size.
// - Three independent bases are kept: general, float and predicate.
// - Every loop branch that rotates decrements the float and predicate bases, and the general base when its region is not empty.
// - p16 is the first stage predicate; its value moves to p17 on rotation.
// - Rotating predicate init writes by physical position, ignoring the base.
// - Each branch first decides continuation; that drives predicate and counters.
// - The branch writes p63 before rotating so the value appears in p16.
// - Each branch selectively decrements loop counter or drain counter, never both.
// - Counted and while branch families each apply their own decisions.
// - Counted branch in prolog/kernel rotates, sets p16, decrements loop counter.
// - Counted branch in epilog rotates, clears p16, decrements drain counter.
// - With drain counter at one: decrement it, rotate once more, exit.
// - While branch ignores loop counter, uses its predicate, always clears p16.
package rot_rename_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFS_FRAME = 8'h00;
  localparam logic [7:0] OFS_BASES = 8'h04;
  localparam logic [7:0] OFS_LOOP = 8'h08;
  localparam logic [7:0] OFS_DRAIN = 8'h0C;
  localparam logic [7:0] OFS_BRANCH = 8'h10;
  localparam logic [7:0] OFS_PRED_LO = 8'h14;
  localparam logic [7:0] OFS_PRED_HI = 8'h18;
  localparam logic [7:0] OFS_RENAME = 8'h1C;
  // Field positions.
  localparam int CMD_QP_BIT = 4;
  localparam int REN_FILE_LSB = 8;
  // Region geometry.
  localparam logic [7:0] GR_FIRST = 8'h20;
  localparam logic [7:0] GR_MAX = 8'h60;
  localparam logic [7:0] FR_FIRST = 8'h20;
  localparam logic [7:0] FR_SIZE = 8'h60;
  localparam logic [7:0] PR_FIRST = 8'h10;
  localparam logic [7:0] PR_SIZE = 8'h30;
  localparam logic [7:0] PR_TOP_OFS = 8'h2F;
  // Reset values.
  localparam logic [6:0] RST_GR_SIZE = 7'h00;
  localparam logic [31:0] RST_LOOP = 32'h0;
  localparam logic [5:0] RST_DRAIN = 6'h00;
  localparam logic [47:0] RST_PREDS = 48'h0;
  // Branch kinds and register files.
  localparam logic [1:0] KIND_CTOP = 2'h0;
  localparam logic [1:0] KIND_CEXIT = 2'h1;
  localparam logic [1:0] KIND_WTOP = 2'h2;
  localparam logic [1:0] FILE_GR = 2'h0;
  localparam logic [1:0] FILE_FR = 2'h1;
  localparam logic [1:0] FILE_PR = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WS_IDLE = 2'h1, WS_RESP = 2'h2} wr_state_e;
  typedef enum logic [1:0] {RS_IDLE = 2'h1, RS_DATA = 2'h2} rd_state_e;

  // Offset plus base, wrapped into a region; both inputs are below size.
  function automatic logic [7:0] rot_add(input logic [7:0] ofs,
      input logic [7:0] base, input logic [7:0] size);
    logic [8:0] sum;
    sum = {1'b0, ofs} + {1'b0, base};
    if (sum >= {1'b0, size}) begin
      sum = sum - {1'b0, size};
    end
    return sum[7:0];
  endfunction

  // Base decrement with wrap; an empty region keeps its base at zero.
  function automatic logic [7:0] base_dec(input logic [7:0] base,
      input logic [7:0] size);
    if (size == 8'h00) begin
      return 8'h00;
    end
    return (base == 8'h00) ? size - 8'h01 : base - 8'h01;
  endfunction
endpackage // rot_rename_pkg

// *** verilog/rotate_index_map.sv ***
// Architectural to physical register index map for the three rotating files.
module rotate_index_map (
  input logic [1:0] file_in,
  input logic [6:0] arch_in,
  input logic [6:0] gr_size_in,
  input logic [6:0] gr_base_in,
  input logic [6:0] fr_base_in,
  input logic [5:0] pr_base_in,
  output logic [6:0] phys_out
);
  logic [7:0] a;
  logic [7:0] res;

  // Only numbers inside a rotating region are renamed; all others pass.
  always_comb begin
    a = {1'b0, arch_in};
    res = a;
    case (file_in)
      rot_rename_pkg::FILE_GR: begin
        if (a >= rot_rename_pkg::GR_FIRST &&
            a < rot_rename_pkg::GR_FIRST + {1'b0, gr_size_in}) begin
          res = rot_rename_pkg::GR_FIRST + rot_rename_pkg::rot_add(
              a - rot_rename_pkg::GR_FIRST, {1'b0, gr_base_in},
              {1'b0, gr_size_in});
        end
      end
      rot_rename_pkg::FILE_FR: begin
        if (a >= rot_rename_pkg::FR_FIRST) begin
          res = rot_rename_pkg::FR_FIRST + rot_rename_pkg::rot_add(
              a - rot_rename_pkg::FR_FIRST, {1'b0, fr_base_in},
              rot_rename_pkg::FR_SIZE);
        end
      end
      rot_rename_pkg::FILE_PR: begin
        if (a >= rot_rename_pkg::PR_FIRST &&
            a < rot_rename_pkg::PR_FIRST + rot_rename_pkg::PR_SIZE) begin
          res = rot_rename_pkg::PR_FIRST + rot_rename_pkg::rot_add(
              a - rot_rename_pkg::PR_FIRST, {2'h0, pr_base_in},
              rot_rename_pkg::PR_SIZE);
        end
      end
      default: res = a;
    endcase
    phys_out = res[6:0];
  end
endmodule // rotate_index_map

// *** verilog/rotating_register_renamer.sv ***
// Rotating register bases, loop branch updates and their AXI4-Lite slave.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
module rotating_register_renamer (
  input logic CLK_SYS_IN,
  input logic SRST_IN,
  input logic CE_IN,
  input logic [7:0] AWADDR_IN,
  input logic AWVALID_IN,
  output logic AWREADY_OUT,
  input logic [31:0] WDATA_IN,
  input logic [3:0] WSTRB_IN,
  input logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input logic BREADY_IN,
  input logic [7:0] ARADDR_IN,
  input logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input logic RREADY_IN
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  rot_rename_pkg::wr_state_e ws, next_ws;
  rot_rename_pkg::rd_state_e rs, next_rs;
  logic aw_held, next_aw_held, w_held, next_w_held, wr_fire;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_mux;
  logic [6:0] gr_size, next_gr_size, gr_base, next_gr_base;
  logic [6:0] fr_base, next_fr_base;
  logic [5:0] pr_base, next_pr_base;
  logic [31:0] loop_cnt, next_loop_cnt;
  logic [5:0] drain_cnt, next_drain_cnt;
  logic [47:0] preds, next_preds, pr_view;
  logic last_taken, next_last_taken, last_cont, next_last_cont;
  logic [1:0] ren_file, next_ren_file;
  logic [6:0] ren_arch, next_ren_arch, ren_phys;
  logic br_fire, cont, rotate, stage_val;
  logic [1:0] kind;
  logic [7:0] p63_idx, pv_idx;
  logic [31:0] merged;

  // Only aligned words up to the last register answer OKAY.
  function automatic logic addr_ok(input logic [7:0] addr);
    return addr[1:0] == 2'h0 && addr <= rot_rename_pkg::OFS_RENAME;
  endfunction

  // Byte lanes without a strobe keep their old contents.
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order, then answered.
  always_comb begin
    next_ws = ws;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = BVALID_OUT;
    next_bresp = BRESP_OUT;
    wr_fire = 1'b0;
    case (ws)
      rot_rename_pkg::WS_IDLE: begin
        if (AWVALID_IN && AWREADY_OUT) begin
          next_aw_held = 1'b1;
          next_waddr = AWADDR_IN;
        end
        if (WVALID_IN && WREADY_OUT) begin
          next_w_held = 1'b1;
          next_wdata = WDATA_IN;
          next_wstrb = WSTRB_IN;
        end
        if (next_aw_held && next_w_held) begin
          wr_fire = 1'b1;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = addr_ok(next_waddr) ? rot_rename_pkg::RESP_OKAY :
                       rot_rename_pkg::RESP_SLVERR;
          next_ws = rot_rename_pkg::WS_RESP;
        end
      end
      rot_rename_pkg::WS_RESP: begin
        if (BREADY_IN) begin
          next_bvalid = 1'b0;
          next_ws = rot_rename_pkg::WS_IDLE;
        end
      end
      default: next_ws = rot_rename_pkg::WS_IDLE;
    endcase
    // Ready flops are computed from next state so they stay exact.
    next_awready = next_ws == rot_rename_pkg::WS_IDLE && !next_aw_held;
    next_wready = next_ws == rot_rename_pkg::WS_IDLE && !next_w_held;
  end

  // Write channel registers; a low clock enable freezes them.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      ws <= rot_rename_pkg::WS_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT <= 1'b0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= rot_rename_pkg::RESP_OKAY;
    end else if (CE_IN) begin
      ws <= next_ws;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      AWREADY_OUT <= next_awready;
      WREADY_OUT <= next_wready;
      BVALID_OUT <= next_bvalid;
      BRESP_OUT <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: the word is sampled on the address handshake.
  always_comb begin
    next_rs = rs;
    next_rvalid = RVALID_OUT;
    next_rdata = RDATA_OUT;
    next_rresp = RRESP_OUT;
    case (rs)
      rot_rename_pkg::RS_IDLE: begin
        if (ARVALID_IN && ARREADY_OUT) begin
          next_rvalid = 1'b1;
          next_rdata = addr_ok(ARADDR_IN) ? rd_mux : 32'h0;
          next_rresp = addr_ok(ARADDR_IN) ? rot_rename_pkg::RESP_OKAY :
                       rot_rename_pkg::RESP_SLVERR;
          next_rs = rot_rename_pkg::RS_DATA;
        end
      end
      rot_rename_pkg::RS_DATA: begin
        if (RREADY_IN) begin
          next_rvalid = 1'b0;
          next_rs = rot_rename_pkg::RS_IDLE;
        end
      end
      default: next_rs = rot_rename_pkg::RS_IDLE;
    endcase
    next_arready = next_rs == rot_rename_pkg::RS_IDLE;
  end

  // Read channel registers.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      rs <= rot_rename_pkg::RS_IDLE;
      ARREADY_OUT <= 1'b0;
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0;
      RRESP_OUT <= rot_rename_pkg::RESP_OKAY;
    end else if (CE_IN) begin
      rs <= next_rs;
      ARREADY_OUT <= next_arready;
      RVALID_OUT <= next_rvalid;
      RDATA_OUT <= next_rdata;
      RRESP_OUT <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rename lookup for the rename window register.
  rotate_index_map u_map (
    .file_in(ren_file),
    .arch_in(ren_arch),
    .gr_size_in(gr_size),
    .gr_base_in(gr_base),
    .fr_base_in(fr_base),
    .pr_base_in(pr_base),
    .phys_out(ren_phys)
  );

  // Readback: predicates are shown by architectural number, through the base.
  always_comb begin
    pv_idx = 8'h00;
    for (int i = 0; i < 48; i++) begin
      pv_idx = rot_rename_pkg::rot_add(8'(i), {2'h0, pr_base},
                                       rot_rename_pkg::PR_SIZE);
      pr_view[i] = preds[pv_idx[5:0]];
    end
    case (ARADDR_IN)
      rot_rename_pkg::OFS_FRAME: rd_mux = {25'h0, gr_size};
      rot_rename_pkg::OFS_BASES:
        rd_mux = {10'h0, pr_base, 1'b0, fr_base, 1'b0, gr_base};
      rot_rename_pkg::OFS_LOOP: rd_mux = loop_cnt;
      rot_rename_pkg::OFS_DRAIN: rd_mux = {26'h0, drain_cnt};
      rot_rename_pkg::OFS_BRANCH: rd_mux = {30'h0, last_cont, last_taken};
      rot_rename_pkg::OFS_PRED_LO: rd_mux = pr_view[31:0];
      rot_rename_pkg::OFS_PRED_HI: rd_mux = {16'h0, pr_view[47:32]};
      rot_rename_pkg::OFS_RENAME:
        rd_mux = {9'h0, ren_arch, 6'h0, ren_file, 1'b0, ren_phys};
      default: rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop branch execution and register writes. Writing the branch register
  // is the only event that decrements a base, so plain accesses never rotate.
  always_comb begin
    next_gr_size = gr_size;
    next_gr_base = gr_base;
    next_fr_base = fr_base;
    next_pr_base = pr_base;
    next_loop_cnt = loop_cnt;
    next_drain_cnt = drain_cnt;
    next_preds = preds;
    next_last_taken = last_taken;
    next_last_cont = last_cont;
    next_ren_file = ren_file;
    next_ren_arch = ren_arch;
    cont = 1'b0;
    rotate = 1'b0;
    stage_val = 1'b0;
    kind = next_wdata[1:0];
    merged = 32'h0;
    p63_idx = rot_rename_pkg::rot_add(rot_rename_pkg::PR_TOP_OFS,
        {2'h0, pr_base}, rot_rename_pkg::PR_SIZE);
    br_fire = wr_fire && next_waddr == rot_rename_pkg::OFS_BRANCH &&
              next_wstrb[0] && kind != 2'h3;
    if (br_fire) begin
      // The continue decision comes first and steers everything else.
      if (kind == rot_rename_pkg::KIND_WTOP ?
          next_wdata[rot_rename_pkg::CMD_QP_BIT] :
          loop_cnt != 32'h0) begin
        cont = 1'b1;
        rotate = 1'b1;
        stage_val = kind != rot_rename_pkg::KIND_WTOP;
        if (kind != rot_rename_pkg::KIND_WTOP) begin
          next_loop_cnt = loop_cnt - 32'h1;
        end
      end else if (drain_cnt > 6'h01) begin
        cont = 1'b1;
        rotate = 1'b1;
        next_drain_cnt = drain_cnt - 6'h01;
      end else if (drain_cnt == 6'h01) begin
        rotate = 1'b1;
        next_drain_cnt = 6'h00;
      end
      // The exit form is taken when the loop does not continue.
      next_last_taken = (kind == rot_rename_pkg::KIND_CEXIT) ? !cont : cont;
      next_last_cont = cont;
    end
    if (rotate) begin
      // p63 is written before the decrement, so it shows up as p16.
      next_preds[p63_idx[5:0]] = stage_val;
      next_gr_base = 7'(rot_rename_pkg::base_dec({1'b0, gr_base},
          {1'b0, gr_size}));
      next_fr_base = 7'(rot_rename_pkg::base_dec({1'b0, fr_base},
          rot_rename_pkg::FR_SIZE));
      next_pr_base = 6'(rot_rename_pkg::base_dec({2'h0, pr_base},
          rot_rename_pkg::PR_SIZE));
    end
    if (wr_fire) begin
      case (next_waddr)
        rot_rename_pkg::OFS_FRAME: begin
          merged = merge({25'h0, gr_size}, next_wdata, next_wstrb);
          // An illegal size is dropped; a legal one restarts the region.
          if (merged[31:7] == 25'h0 && merged[2:0] == 3'h0 &&
              merged[7:0] <= rot_rename_pkg::GR_MAX) begin
            next_gr_size = merged[6:0];
            next_gr_base = 7'h00;
          end
        end
        rot_rename_pkg::OFS_LOOP:
          next_loop_cnt = merge(loop_cnt, next_wdata, next_wstrb);
        rot_rename_pkg::OFS_DRAIN: begin
          merged = merge({26'h0, drain_cnt}, next_wdata, next_wstrb);
          next_drain_cnt = merged[5:0];
        end
        rot_rename_pkg::OFS_PRED_LO: begin
          merged = merge(preds[31:0], next_wdata, next_wstrb);
          next_preds[31:0] = merged;
        end
        rot_rename_pkg::OFS_PRED_HI: begin
          merged = merge({16'h0, preds[47:32]}, next_wdata, next_wstrb);
          next_preds[47:32] = merged[15:0];
        end
        rot_rename_pkg::OFS_RENAME: begin
          merged = merge({22'h0, ren_file, 1'b0, ren_arch}, next_wdata,
                         next_wstrb);
          next_ren_file = merged[rot_rename_pkg::REN_FILE_LSB +: 2];
          next_ren_arch = merged[6:0];
        end
        default: merged = 32'h0;
      endcase
    end
  end

  // Renamer state registers.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      gr_size <= rot_rename_pkg::RST_GR_SIZE;
      gr_base <= 7'h00;
      fr_base <= 7'h00;
      pr_base <= 6'h00;
      loop_cnt <= rot_rename_pkg::RST_LOOP;
      drain_cnt <= rot_rename_pkg::RST_DRAIN;
      preds <= rot_rename_pkg::RST_PREDS;
      last_taken <= 1'b0;
      last_cont <= 1'b0;
      ren_file <= rot_rename_pkg::FILE_GR;
      ren_arch <= 7'h00;
    end else if (CE_IN) begin
      gr_size <= next_gr_size;
      gr_base <= next_gr_base;
      fr_base <= next_fr_base;
      pr_base <= next_pr_base;
      loop_cnt <= next_loop_cnt;
      drain_cnt <= next_drain_cnt;
      preds <= next_preds;
      last_taken <= next_last_taken;
      last_cont <= next_last_cont;
      ren_file <= next_ren_file;
      ren_arch <= next_ren_arch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Branch checks look one edge after a branch fired with CE high; the range and size checks hold on every edge.
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);

  logic fire_ce, ctd;
  assign fire_ce = br_fire && CE_IN;
  assign ctd = kind != rot_rename_pkg::KIND_WTOP;

  chk_bases_together: assert property (fire_ce && rotate |=>
      fr_base == 7'(rot_rename_pkg::base_dec({1'b0, $past(fr_base)},
          rot_rename_pkg::FR_SIZE)) &&
      pr_base == 6'(rot_rename_pkg::base_dec({2'h0, $past(pr_base)},
          rot_rename_pkg::PR_SIZE)))
    else $error("Bases did not decrement together.");
  chk_base_range: assert property (fr_base < 7'h60 &&
      pr_base < 6'h30 && (gr_size == 7'h00 || gr_base < gr_size))
    else $error("A rotating base left its region.");
  chk_gr_static: assert property (gr_size == 7'h00 |->
      gr_base == 7'h00)
    else $error("General base moved with an empty region.");
  chk_size_legal: assert property (gr_size[2:0] == 3'h0 &&
      gr_size <= 7'h60)
    else $error("General rotating size is illegal.");
  chk_no_idle_rotate: assert property (CE_IN && !rotate |=>
      $stable(fr_base) && $stable(pr_base))
    else $error("Bases moved without a loop branch.");
  chk_stage_to_p16: assert property (fire_ce && rotate |=>
      pr_view[0] == ($past(ctd) && $past(cont) &&
                     $past(loop_cnt) != 32'h0))
    else $error("First stage predicate has the wrong value.");
  chk_prolog_count: assert property (fire_ce && ctd &&
      loop_cnt != 32'h0 |=> loop_cnt == $past(loop_cnt) - 32'h1 &&
      $stable(drain_cnt) && last_cont)
    else $error("Counted prolog branch updated counters wrongly.");
  chk_epilog_drain: assert property (fire_ce && ctd &&
      loop_cnt == 32'h0 && drain_cnt > 6'h01 |=>
      drain_cnt == $past(drain_cnt) - 6'h01 && last_cont && !pr_view[0])
    else $error("Epilog branch did not drain.");
  chk_final_exit: assert property (fire_ce && !cont &&
      drain_cnt == 6'h01 |=> drain_cnt == 6'h00 && !last_cont &&
      !$stable(pr_base))
    else $error("Last drain stage did not rotate and exit.");
  chk_while_lc: assert property (fire_ce && !ctd |=>
      $stable(loop_cnt) && (!$past(rotate) || !pr_view[0]))
    else $error("While branch touched the loop counter.");

  cov_epilog_exit: cover property (fire_ce && ctd && drain_cnt == 6'h01);
  cov_while_cont: cover property (fire_ce && !ctd && cont);
  cov_exit_taken: cover property (fire_ce &&
      kind == rot_rename_pkg::KIND_CEXIT && !cont);
  cov_gr_wrap: cover property (fire_ce && gr_size != 7'h00 &&
      gr_base == 7'h00);
endmodule // rotating_register_renamer

// *** tb/axil_master.sv ***
// Behavioural AXI4-Lite master standing in for the branch issue logic.
module axil_master (
  input logic clk_in,
  input logic go_in,
  input logic we_in,
  input logic [7:0] addr_in,
  input logic [31:0] data_in,
  output logic busy_out,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input logic awready_in,
  output logic [31:0] wdata_out,
  output logic wvalid_out,
  input logic wready_in,
  input logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input logic arready_in,
  input logic rvalid_in,
  output logic rready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, wdata_out, araddr_out} = 48'h0;
  end
  // Payload is held until its own handshake; released lines then show the
  // inverse so a stale value can never pass for a fresh one.
  always @(posedge clk_in) begin
    if (go_in && we_in) begin
      {awvalid_out, wvalid_out, bready_out} <= 3'h7;
      awaddr_out <= addr_in;
      wdata_out <= data_in;
    end
    if (go_in && !we_in) begin
      {arvalid_out, rready_out} <= 2'h3;
      araddr_out <= addr_in;
    end
    if (awvalid_out && awready_in)
      {awvalid_out, awaddr_out} <= {1'b0, ~awaddr_out};
    if (wvalid_out && wready_in) {wvalid_out, wdata_out} <= {1'b0, ~wdata_out};
    if (bready_out && bvalid_in) bready_out <= 1'b0;
    if (arvalid_out && arready_in)
      {arvalid_out, araddr_out} <= {1'b0, ~araddr_out};
    if (rready_out && rvalid_in) rready_out <= 1'b0;
  end
  assign busy_out = awvalid_out | wvalid_out | bready_out | arvalid_out |
                    rready_out;
endmodule // axil_master

// *** tb/testbench.sv ***
// Self-checking bench for the rotating register renamer.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, go, we, busy, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [7:0] ad, awa, ara;
  logic [31:0] wd, wdat, rdat;
  logic [1:0] bresp, rresp;
  logic [33:0] q[$];
  int err_count, comparisons, cyc;
  logic [6:0] gb, fb, gs;
  logic [5:0] pb, dc;
  logic [47:0] pr, v;
  logic [31:0] lc;
  rotating_register_renamer i_dut (.CLK_SYS_IN(clk), .SRST_IN(rst),
    .CE_IN(1'b1),
    .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wdat),
    .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(wr_rdy), .BRESP_OUT(bresp),
    .BVALID_OUT(bv), .BREADY_IN(br), .ARADDR_IN(ara), .ARVALID_IN(arv),
    .ARREADY_OUT(arr), .RDATA_OUT(rdat), .RRESP_OUT(rresp), .RVALID_OUT(rv),
    .RREADY_IN(rr));
  axil_master i_master (.clk_in(clk), .go_in(go), .we_in(we), .addr_in(ad),
    .data_in(wd), .busy_out(busy), .awaddr_out(awa), .awvalid_out(awv),
    .awready_in(awr), .wdata_out(wdat), .wvalid_out(wv), .wready_in(wr_rdy),
    .bvalid_in(bv), .bready_out(br), .araddr_out(ara), .arvalid_out(arv),
    .arready_in(arr), .rvalid_in(rv), .rready_out(rr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0 && q.size() == 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Monitor: every accepted response is matched against the oldest note.
  always @(posedge clk) begin
    if (bv && br) chk({bresp, 32'h0}, q.pop_front());
    if (rv && rr) chk({rresp, rdat}, q.pop_front());
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] e);
    q.push_back(e);
    {go, we, ad, wd} <= {1'b1, w, a, d};
    @(posedge clk) go <= 1'b0;
    // Waits for the answer however long it takes; the cycle ceiling ends a hang.
    do @(posedge clk); while (busy);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, {rot_rename_pkg::RESP_OKAY, 32'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    acc(1'b0, a, 32'h0, {rot_rename_pkg::RESP_OKAY, d});
  endtask
  // Expected physical number; names outside a region map to themselves.
  function automatic logic [6:0] ph(input logic [1:0] f, input logic [6:0] a);
    ph = a;
    if (f == 2'h0 && a >= 32 && a < 32 + gs) ph = 7'(32 + (a - 32 + gb) % gs);
    if (f == 2'h1 && a >= 32) ph = 7'(32 + (a - 32 + fb) % 96);
    if (f == 2'h2 && a >= 16) ph = 7'(16 + (a - 16 + pb) % 48);
  endfunction
  task automatic step(input logic [1:0] k, input logic qb);
    logic ct, rot, p;
    logic [1:0] f;
    logic [6:0] a;
    {ct, rot, p} = 3'h0;
    if (k != 2'h3) begin
      if (k != 2'h2 && lc != 0) {ct, p, lc} = {2'h3, lc - 32'h1};
      else if (k == 2'h2 && qb) ct = 1'b1;
      else if (dc > 1) {ct, dc} = {1'b1, dc - 6'h01};
      else if (dc == 1) {rot, dc} = {1'b1, 6'h00};
      if (rot | ct) begin
        pr[(47 + pb) % 48] = p;
        pb = (pb == 0) ? 6'h2F : pb - 6'h01;
        fb = (fb == 0) ? 7'h5F : fb - 7'h01;
        if (gs != 0) gb = (gb == 0) ? gs - 7'h01 : gb - 7'h01;
      end
    end
    wr(8'h10, {27'h0, qb, 2'h0, k});
    if (k != 2'h3) rd(8'h10, {30'h0, ct, (k == 2'h1) ? !ct : ct});
    rd(8'h04, {10'h0, pb, 1'b0, fb, 1'b0, gb});
    rd(8'h08, lc);
    rd(8'h0C, {26'h0, dc});
    for (int i = 0; i < 48; i++) v[i] = pr[(i + pb) % 48];
    rd(8'h14, v[31:0]);
    rd(8'h18, {16'h0, v[47:32]});
    f = 2'($urandom % 3);
    a = 7'($urandom % ((f == 2'h2) ? 64 : 128));
    wr(8'h1C, {22'h0, f, 1'b0, a});
    rd(8'h1C, {9'h0, a, 6'h0, f, 1'b0, ph(f, a)});
  endtask
  // Main sequence: reset, idle map, then randomised loop branch traffic.
  initial begin
    {rst, go, we, ad, wd} = 0;
    {gb, fb, gs, pb, dc, pr, lc} = 0;
    void'($urandom(13));
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && !arr; i++) @(posedge clk);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    acc(1'b0, 8'h20, 32'h0, {rot_rename_pkg::RESP_SLVERR, 32'h0});
    acc(1'b1, 8'h02, 32'h5, {rot_rename_pkg::RESP_SLVERR, 32'h0});
    repeat (3) step(2'h2, 1'b1);
    $display("reset and empty region done");
    for (int n = 0; n < 60; n++) begin
      if (n % 10 == 0) begin
        {gs, gb, lc, dc} = {7'(8 * ($urandom % 13)), 7'h0, 32'($urandom % 4),
          6'($urandom % 4)};
        wr(8'h00, {25'h0, gs});
        wr(8'h08, lc);
        wr(8'h0C, {26'h0, dc});
        pr = {16'($urandom), 32'($urandom)};
        wr(8'h14, pr[31:0]);
        wr(8'h18, {16'h0, pr[47:32]});
      end
      step(2'($urandom), 1'($urandom));
    end
    $display("branch traffic done");
    wr(8'h00, 32'hC);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h00, {25'h0, gs});
    rd(8'h04, {10'h0, pb, 1'b0, fb, 1'b0, gb});
    $display("ignored writes done");
    complete_run();
  end
endmodule // testbench
